/* File: call_return_stack_params.svh */
// constants for the subroutine return-address stack
`ifndef CALL_RETURN_STACK_PARAMS_SVH
`define CALL_RETURN_STACK_PARAMS_SVH

`define CRS_ADDR_W        12    // full program counter width
`define CRS_ADDR_W_SMALL  11    // smaller-memory variant width
`define CRS_DEPTH         8     // full stack depth
`define CRS_SHALLOW_DEPTH 2     // depth when limited
`define CRS_LIT_W         8     // immediate literal width
`define CRS_PAGE_W        3     // page-select field width
`define CRS_PAGE_LSB      9     // page field position in address
`define CRS_BIT8_VALUE    1'h0  // call target bit 8
`define CRS_REG_RST       8'h00 // reset value of saved registers

`endif

/* File: call_return_stack_pkg.sv */
// types shared by the subroutine return-address stack
`default_nettype none
package call_return_stack_pkg;

  // return instruction flavour given by the decoder
  typedef enum logic [2:0] {
    return_plain                  = 3'h0,
    return_set_page               = 3'h1,
    return_with_literal           = 3'h2,
    interrupt_return              = 3'h3,
    interrupt_return_adjust_timer = 3'h4
  } ret_kind_type;

endpackage
`default_nettype wire

/* File: call_return_stack.sv */
// return-address stack and return-instruction effects of the core
`timescale 1ns/1ns
`default_nettype none
`include "call_return_stack_params.svh"

// How it works
// - subroutine return reloads whole program counter
// - resume address ignores page-select bits
// - plain return touches only counter, stack
// - page return copies address bits 11:9
// - literal return loads literal into accumulator
// - interrupt return restores pc, w, status, pointer
// - timer return also adds w to counter
// - call pushes address of following instruction
// - eight-entry lifo, 12 or 11 bits
// - default eight entries, select bit limits to two
// - stack reachable only by call, return
// - no pointer; entries shift each push, pop
// - call writes top, shifts down, drops bottom
// - return pops top, shifts up, bottom kept
// - interrupt entry and returns leave stack alone
// - select bit one gives two entries
// - call target bit 8 zero, literal low
module call_return_stack
  import call_return_stack_pkg::*;
#(
  parameter int ADDR_W = `CRS_ADDR_W,  // 12, or 11 on small variant
  parameter int DEPTH  = `CRS_DEPTH    // full depth
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    stack_depth_select,
  input  wire logic                    call_req,
  input  wire logic [`CRS_LIT_W-1:0]   call_lit,
  input  wire logic [`CRS_PAGE_W-1:0]  page_select_bits,
  input  wire logic [ADDR_W-1:0]       return_addr,
  input  wire logic                    ret_req,
  input  wire ret_kind_type            ret_kind,
  input  wire logic [`CRS_LIT_W-1:0]   ret_lit,
  input  wire logic                    int_take,
  input  wire logic [ADDR_W-1:0]       int_resume_addr,
  input  wire logic [7:0]              w_in,
  input  wire logic [7:0]              status_in,
  input  wire logic [7:0]              file_select_pointer_in,
  output logic                         pc_load,
  output logic [ADDR_W-1:0]            pc_value,
  output logic                         w_load,
  output logic [7:0]                   w_value,
  output logic                         page_load,
  output logic [`CRS_PAGE_W-1:0]       page_value,
  output logic                         status_load,
  output logic [7:0]                   status_value,
  output logic                         fptr_load,
  output logic [7:0]                   fptr_value,
  output logic                         cnt_add,
  output logic [7:0]                   cnt_add_value
);

  // refuse widths and depths the shifter cannot serve
  if (!(ADDR_W == `CRS_ADDR_W || ADDR_W == `CRS_ADDR_W_SMALL) ||
      DEPTH <= `CRS_SHALLOW_DEPTH) begin : g_bad_params
    $error("call_return_stack: unsupported ADDR_W or DEPTH");
  end

  // whole module state in one record
  typedef struct packed {
    logic [DEPTH-1:0][ADDR_W-1:0] stk;          // entry 0 is top
    logic [ADDR_W-1:0]            sh_pc;        // shadow resume address
    logic [7:0]                   sh_w;         // shadow accumulator
    logic [7:0]                   sh_status;    // shadow status
    logic [7:0]                   sh_fptr;      // shadow file pointer
    logic                         pc_load;
    logic [ADDR_W-1:0]            pc_value;
    logic                         w_load;
    logic [7:0]                   w_value;
    logic                         page_load;
    logic [`CRS_PAGE_W-1:0]       page_value;
    logic                         status_load;
    logic [7:0]                   status_value;
    logic                         fptr_load;
    logic [7:0]                   fptr_value;
    logic                         cnt_add;
    logic [7:0]                   cnt_add_value;
  } state_type;

  state_type st_ff;   // registered state
  state_type nxt_st;  // next state
  int        last_idx; // lowest live entry
  logic [`CRS_ADDR_W-1:0] popped_wide; // top entry at full width

  // active entries: select bit high limits to two
  assign last_idx = stack_depth_select ? (`CRS_SHALLOW_DEPTH - 1)
                                       : (DEPTH - 1);
  assign popped_wide = `CRS_ADDR_W'(st_ff.stk[0]);

  // next-state logic; one operation per instruction
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.pc_load     = 1'h0;
    nxt_st.w_load      = 1'h0;
    nxt_st.page_load   = 1'h0;
    nxt_st.status_load = 1'h0;
    nxt_st.fptr_load   = 1'h0;
    nxt_st.cnt_add     = 1'h0;
    if (call_req) begin
      // push: new top, shift live entries down, bottom lost
      nxt_st.stk[0] = return_addr;
      for (int i = 1; i < DEPTH; i++) begin
        if (i <= last_idx) begin
          nxt_st.stk[i] = st_ff.stk[i-1];
        end
      end
      // target: page bits, bit 8 cleared, literal low
      nxt_st.pc_load  = 1'h1;
      nxt_st.pc_value = ADDR_W'({page_select_bits, `CRS_BIT8_VALUE,
                                 call_lit});
    end else if (ret_req) begin
      unique case (ret_kind)
        return_plain, return_set_page, return_with_literal: begin
          // pop: shift live entries up, lowest live kept
          // loop bound keeps i+1 inside the array
          for (int i = 0; i < DEPTH - 1; i++) begin
            if (i < last_idx) begin
              nxt_st.stk[i] = st_ff.stk[i+1];
            end
          end
          // full address reload, page bits not used
          nxt_st.pc_load  = 1'h1;
          nxt_st.pc_value = st_ff.stk[0];
          if (ret_kind == return_set_page) begin
            nxt_st.page_load  = 1'h1;
            nxt_st.page_value =
              popped_wide[`CRS_PAGE_LSB +: `CRS_PAGE_W];
          end
          if (ret_kind == return_with_literal) begin
            nxt_st.w_load  = 1'h1;
            nxt_st.w_value = ret_lit;
          end
        end
        interrupt_return, interrupt_return_adjust_timer: begin
          // restore from shadow, stack untouched
          nxt_st.pc_load      = 1'h1;
          nxt_st.pc_value     = st_ff.sh_pc;
          nxt_st.w_load       = 1'h1;
          nxt_st.w_value      = st_ff.sh_w;
          nxt_st.status_load  = 1'h1;
          nxt_st.status_value = st_ff.sh_status;
          nxt_st.fptr_load    = 1'h1;
          nxt_st.fptr_value   = st_ff.sh_fptr;
          if (ret_kind == interrupt_return_adjust_timer) begin
            // add current accumulator to the counter
            nxt_st.cnt_add       = 1'h1;
            nxt_st.cnt_add_value = w_in;
          end
        end
        default: begin
          // illegal code: no effect
          nxt_st.pc_load = 1'h0;
        end
      endcase
    end else if (int_take) begin
      // interrupt entry saves shadows, no push
      nxt_st.sh_pc     = int_resume_addr;
      nxt_st.sh_w      = w_in;
      nxt_st.sh_status = status_in;
      nxt_st.sh_fptr   = file_select_pointer_in;
    end
  end

  // state register; stack has no software access port
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign pc_load        = st_ff.pc_load;
  assign pc_value       = st_ff.pc_value;
  assign w_load         = st_ff.w_load;
  assign w_value        = st_ff.w_value;
  assign page_load      = st_ff.page_load;
  assign page_value     = st_ff.page_value;
  assign status_load    = st_ff.status_load;
  assign status_value   = st_ff.status_value;
  assign fptr_load      = st_ff.fptr_load;
  assign fptr_value     = st_ff.fptr_value;
  assign cnt_add        = st_ff.cnt_add;
  assign cnt_add_value  = st_ff.cnt_add_value;

  // decoded operations for the checks
  logic op_sub_ret; // subroutine return taken
  logic op_int_ret; // interrupt return taken
  assign op_sub_ret = !call_req && ret_req &&
    (ret_kind == return_plain || ret_kind == return_set_page ||
     ret_kind == return_with_literal);
  assign op_int_ret = !call_req && ret_req &&
    (ret_kind == interrupt_return ||
     ret_kind == interrupt_return_adjust_timer);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // call target formed from page, zero bit 8, literal
  property p_call_target;
    call_req |=> pc_load && pc_value ==
      ADDR_W'({$past(page_select_bits), 1'h0, $past(call_lit)});
  endproperty
  a_call_target: assert property (p_call_target)
    else $error("call target address wrong");

  // call pushes return address, old top moves down
  property p_call_push;
    call_req |=> st_ff.stk[0] == $past(return_addr) &&
                 st_ff.stk[1] == $past(st_ff.stk[0]);
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call push wrong");

  // return reloads counter from old top, next entry rises
  property p_ret_pop;
    op_sub_ret |=> pc_load && pc_value == $past(st_ff.stk[0]) &&
                   st_ff.stk[0] == $past(st_ff.stk[1]);
  endproperty
  a_ret_pop: assert property (p_ret_pop)
    else $error("subroutine return pop wrong");

  // plain return drives no register loads besides program counter
  property p_plain_quiet;
    (op_sub_ret && ret_kind == return_plain) |=>
      !w_load && !page_load && !status_load && !fptr_load && !cnt_add;
  endproperty
  a_plain_quiet: assert property (p_plain_quiet)
    else $error("plain return touched a register");

  // page return copies top address bits into page field
  property p_page_copy;
    (op_sub_ret && ret_kind == return_set_page) |=> page_load &&
      page_value == $past(popped_wide[`CRS_PAGE_LSB +: `CRS_PAGE_W]);
  endproperty
  a_page_copy: assert property (p_page_copy)
    else $error("page return copy wrong");

  // literal return loads literal into accumulator
  property p_lit_load;
    (op_sub_ret && ret_kind == return_with_literal) |=>
      w_load && w_value == $past(ret_lit) && pc_load;
  endproperty
  a_lit_load: assert property (p_lit_load)
    else $error("literal return wrong");

  // interrupt return restores shadows, stack still
  property p_int_restore;
    op_int_ret |=> pc_value == $past(st_ff.sh_pc) &&
      status_load && fptr_load && $stable(st_ff.stk);
  endproperty
  a_int_restore: assert property (p_int_restore)
    else $error("interrupt return restore wrong");

  // timer return adds accumulator to counter
  property p_timer_add;
    (op_int_ret && ret_kind == interrupt_return_adjust_timer) |=>
      cnt_add && cnt_add_value == $past(w_in);
  endproperty
  a_timer_add: assert property (p_timer_add)
    else $error("timer adjust wrong");

  // interrupt entry leaves the stack alone
  property p_int_nostack;
    (int_take && !call_req && !ret_req) |=> $stable(st_ff.stk);
  endproperty
  a_int_nostack: assert property (p_int_nostack)
    else $error("interrupt entry moved stack");

  // shallow mode never disturbs third entry
  property p_shallow;
    stack_depth_select |=> st_ff.stk[2] == $past(st_ff.stk[2]);
  endproperty
  a_shallow: assert property (p_shallow)
    else $error("shallow mode touched third entry");

  // main scenarios
  c_call_then_ret: cover property (call_req ##1 op_sub_ret);
  c_page_return: cover property (op_sub_ret &&
                                 ret_kind == return_set_page);
  c_int_cycle: cover property (int_take ##[1:20] op_int_ret);
  c_deep: cover property (!stack_depth_select && call_req [*4]);

endmodule
`default_nettype wire

/* File: core_model.sv */
// behavioural core registers fed by the stack's load strobes
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        set_en,
  input  wire logic [7:0]  set_w,
  input  wire logic [7:0]  set_status,
  input  wire logic [7:0]  set_fptr,
  input  wire logic        pc_load,
  input  wire logic [11:0] pc_value,
  input  wire logic        w_load,
  input  wire logic [7:0]  w_value,
  input  wire logic        page_load,
  input  wire logic [2:0]  page_value,
  input  wire logic        status_load,
  input  wire logic [7:0]  status_value,
  input  wire logic        fptr_load,
  input  wire logic [7:0]  fptr_value,
  input  wire logic        cnt_add,
  input  wire logic [7:0]  cnt_add_value,
  output logic      [7:0]  w_ff,
  output logic      [7:0]  status_ff,
  output logic      [7:0]  fptr_ff
);
  logic [11:0] pc_ff;  // program counter
  logic [7:0]  cnt_ff; // free-running counter
  // bench moves first, then the stack's loads win
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {pc_ff, w_ff, status_ff, fptr_ff, cnt_ff} <= '0;
    end else begin
      pc_ff  <= pc_load ? pc_value : pc_ff + 12'h001;
      cnt_ff <= cnt_ff + 8'h01 + (cnt_add ? cnt_add_value : 8'h00);
      if (set_en) {w_ff, status_ff, fptr_ff} <= {set_w, set_status, set_fptr};
      if (w_load) w_ff <= w_value;
      if (status_load) status_ff <= status_value;
      if (page_load) status_ff[7:5] <= page_value; // page bits sit in status
      if (fptr_load) fptr_ff <= fptr_value;
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// random self-checking bench for the return-address stack
`timescale 1ns/1ns
`default_nettype none
module tb;
  import call_return_stack_pkg::*;
  typedef struct packed {
    logic [5:0]  strb;
    logic [11:0] pc;
    logic [7:0]  w;
    logic [2:0]  pg;
    logic [7:0]  st;
    logic [7:0]  fs;
    logic [7:0]  rt;
  } note_type;                     // expected output picture
  logic         core_clk = 1'b0, rst_b = 1'b0, stack_depth_select = 1'b0;
  logic         call_req = 1'b0, ret_req = 1'b0, int_take = 1'b0;
  logic         set_en = 1'b0;     // bench move into core registers
  logic [7:0]   call_lit = 8'h00, ret_lit = 8'h00;
  logic [7:0]   set_w = 8'h00, set_status = 8'h00, set_fptr = 8'h00;
  logic [11:0]  return_addr = 12'h000, int_resume_addr = 12'h000;
  ret_kind_type ret_kind = return_plain;
  logic         pc_load, w_load, page_load, status_load, fptr_load, cnt_add;
  logic [11:0]  pc_value;
  logic [7:0]   w_value, status_value, fptr_value, cnt_add_value;
  logic [7:0]   w_now, status_now, fptr_now;
  logic [2:0]   page_value, page_select_bits;
  logic [11:0]  stk [8] = '{default: 12'h000}; // stack picture
  logic [11:0]  sh_pc = 12'h000;   // interrupt shadows
  logic [7:0]   sh_w = 8'h00, sh_st = 8'h00, sh_fs = 8'h00;
  note_type     held = '0;         // last loaded values
  note_type     q [$];             // pending expectations
  int           seed = 75, err_count = 0, total_checks = 0;
  assign page_select_bits = status_now[7:5];
  call_return_stack DUT (.core_clk, .rst_b, .stack_depth_select, .call_req,
    .call_lit, .page_select_bits, .return_addr, .ret_req, .ret_kind,
    .ret_lit, .int_take, .int_resume_addr, .w_in(w_now),
    .status_in(status_now), .file_select_pointer_in(fptr_now), .pc_load,
    .pc_value, .w_load, .w_value, .page_load, .page_value, .status_load,
    .status_value, .fptr_load, .fptr_value, .cnt_add, .cnt_add_value);
  core_model partner (.core_clk, .rst_b, .set_en, .set_w, .set_status,
    .set_fptr, .pc_load, .pc_value, .w_load, .w_value, .page_load,
    .page_value, .status_load, .status_value, .fptr_load, .fptr_value,
    .cnt_add, .cnt_add_value, .w_ff(w_now), .status_ff(status_now),
    .fptr_ff(fptr_now));
  always #5 core_clk = ~core_clk;
  // compare one value and count it
  task automatic check(input string name, input logic [11:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic results();
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one random cycle of requests plus its expected answer
  task automatic step();
    logic [31:0] r1, r2, r3;
    note_type    n;
    int          live;
    r1 = $random(seed);
    r2 = $random(seed);
    r3 = $random(seed);
    // nesting limit and underflow broken on purpose; picture predicts
    call_req = r1[0] & r1[1];
    ret_req = r1[2];
    ret_kind = ret_kind_type'(r1[7:5]);
    int_take = r1[3] & ~(r1[2] & r1[7] & (r1[6] | r1[5])); // no odd kinds
    {ret_lit, call_lit} = r1[23:8];
    {int_resume_addr, return_addr} = r2[23:0];
    set_en = r2[24] & r2[25];
    {set_w, set_status, set_fptr} = r3[23:0];
    if (r3[31:26] == 6'h00) stack_depth_select = ~stack_depth_select;
    live = stack_depth_select ? 2 : 8;
    n = held;
    n.strb = 6'h00;
    if (call_req) begin
      for (int i = 7; i > 0; i--) if (i < live) stk[i] = stk[i-1];
      stk[0] = return_addr;
      n.pc = {status_now[7:5], 1'b0, call_lit};
      n.strb = 6'h20;
    end else if (ret_req && ret_kind <= return_with_literal) begin
      n.pc = stk[0];
      n.strb = 6'h20;
      if (ret_kind == return_set_page) begin
        n.pg = stk[0][11:9];
        n.strb = 6'h28;
      end
      if (ret_kind == return_with_literal) begin
        n.w = ret_lit;
        n.strb = 6'h30;
      end
      for (int i = 0; i < 7; i++) if (i < live - 1) stk[i] = stk[i+1];
    end else if (ret_req && ret_kind <= interrupt_return_adjust_timer) begin
      {n.pc, n.w, n.st, n.fs} = {sh_pc, sh_w, sh_st, sh_fs};
      n.strb = (ret_kind == interrupt_return) ? 6'h36 : 6'h37;
      if (ret_kind == interrupt_return_adjust_timer) n.rt = w_now;
    end else if (int_take) begin
      {sh_pc, sh_w, sh_st, sh_fs} =
        {int_resume_addr, w_now, status_now, fptr_now};
    end
    if (n.strb != 6'h00) begin
      q.push_back(n);
      held = n;
    end
  endtask
  // watch strobes and take the oldest note for each answer
  always @(negedge core_clk) begin
    note_type e;
    logic [5:0] seen;
    seen = {pc_load, w_load, page_load, status_load, fptr_load, cnt_add};
    if (rst_b === 1'b1 && seen !== 6'h00) begin
      e = (q.size() > 0) ? q.pop_front() : '0;
      check("strobes", 12'(seen), 12'(e.strb));
      check("pc", pc_value, e.pc);
      check("w", 12'(w_value), 12'(e.w));
      check("page", 12'(page_value), 12'(e.pg));
      check("status", 12'(status_value), 12'(e.st));
      check("fptr", 12'(fptr_value), 12'(e.fs));
      check("count", 12'(cnt_add_value), 12'(e.rt));
    end
  end
  // watchdog against a hang
  initial begin
    #100000;
    err_count++;
    results();
  end
  // reset, random traffic, drain
  initial begin
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4000) begin
      @(negedge core_clk);
      step();
    end
    @(negedge core_clk);
    {call_req, ret_req, int_take, set_en} = 4'h0;
    repeat (3) @(negedge core_clk);
    check("pending", 12'(q.size()), 12'h000);
    results();
  end
endmodule
`default_nettype wire
